// ### verilog/txcrd_pkg.sv
// Package of register layout, reset values and decode types for the transmitter control bank.
package txcrd_pkg;

  // ==========================================================================
  // Serial frame
  // ==========================================================================
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned ADDR_BITS  = 4;
  localparam int unsigned DATA_BITS  = 16;

  localparam logic [3:0] ADDR_OPERATION_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_SETUP  = 4'h5;
  localparam logic [3:0] ADDR_BIAS   = 4'h6;

  localparam logic [15:0] RST_OPERATION_CONTROL = 16'h090f;
  localparam logic [15:0] RST_SETUP  = 16'hd03f;
  localparam logic [15:0] RST_BIAS   = 16'h0038;

  // ==========================================================================
  // Operation register fields
  // ==========================================================================
  localparam int unsigned OP_LO_PORT_SELECT   = 15;
  localparam int unsigned OP_BOOST_A  = 14;
  localparam int unsigned OP_IF_HOLD  = 13;
  localparam int unsigned OP_MODE_HI  = 12;
  localparam int unsigned OP_MODE_LO  = 11;
  localparam int unsigned OP_IF_PORT  = 10;
  localparam int unsigned OP_OSC_BAND = 9;
  localparam int unsigned OP_GAIN_HI  = 8;
  localparam int unsigned OP_GAIN_LO  = 6;
  localparam int unsigned OP_SIDE     = 5;
  localparam int unsigned OP_BUF_ON   = 4;
  localparam int unsigned OP_MOD_KIND = 3;
  localparam int unsigned OP_SLEEP_N  = 2;
  localparam int unsigned OP_TXSLP_N  = 1;
  localparam int unsigned OP_OFF_N    = 0;

  // ==========================================================================
  // Setup register fields
  // ==========================================================================
  localparam int unsigned SU_IF_SYN_N = 15;
  localparam int unsigned SU_RF_SYN_N = 14;
  localparam int unsigned SU_BOOST_B  = 13;

  // ==========================================================================
  // Bias register fields
  // ==========================================================================
  localparam int unsigned BI_PRESCALE = 13;
  localparam int unsigned BI_MAXPWR   = 11;
  localparam int unsigned BI_THERM_HI = 10;
  localparam int unsigned BI_THERM_LO = 9;
  localparam int unsigned BI_SKIP     = 7;
  localparam int unsigned BI_SLOPE_HI = 6;
  localparam int unsigned BI_SLOPE_LO = 4;
  localparam int unsigned BI_DRV_HI   = 3;
  localparam int unsigned BI_DRV_LO   = 0;

  typedef enum logic [3:0] {
    TXCRD_MODE_FM    = 4'b0001,
    TXCRD_MODE_CELL  = 4'b0010,
    TXCRD_MODE_PCS_L = 4'b0100,
    TXCRD_MODE_PCS_U = 4'b1000
  } txcrd_mode_t;

  typedef struct packed {
    logic       boost_off;
    logic       boost_reprog;
    logic       boost_always;
    logic       boost_unlock;
  } txcrd_boost_t;

  typedef struct packed {
    logic cell_band_driver;
    logic pcs_lower_driver;
    logic pcs_upper_driver;
  } txcrd_drv_t;

  typedef struct packed {
    logic lo_low_port;
    logic lo_high_port;
    logic if_low_sel;
    logic if_high_sel;
    logic osc_high;
    logic osc_low;
  } txcrd_route_t;

endpackage : txcrd_pkg

// ### verilog/txcrd_top.sv
// Serial-loaded control bank and decode for a dual-band transmitter.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// (R1) Bit 15 of operation register routes low LO port at 0, high at 1.
// (R2) RF pump-boost pair decodes to none, after-reprogram, permanent or out-of-lock.
// (R3) Bit 13 set holds IF charge-pump boost after acquisition.
// (R4) Mode bits 12:11 pick FM, cellular, lower PCS or upper PCS driver.
// (R5) Bit 10 picks high or low IF pair; controller writes 0 in FM.
// (R6) Bit 9 picks high or low band IF oscillator.
// (R7) Bits 8:6 output as IF gain code, about 2 dB per step.
// (R8) Bit 5 picks upper sideband at 1, lower sideband at 0.
// (R9) Bit 4 switches buffered IF LO output.
// (R10) Bit 3 picks quadrature modulation, else direct oscillator modulation.
// (R11) Bit 2 low powers down all but registers and serial port.
// (R12) Bit 1 low powers down modulator and upconverter, synthesizers stay locked.
// (R13) Bit 0 low powers down all but serial port, registers kept.
// (R14) Setup bits 15 and 14 low disable IF and RF synthesizers.
// (R15) Controller writes zeros to reserved bias bits 15, 14, 12, 8.
// (R16) Bias bit 13 picks lower or higher band prescaler.
// (R17) Bias bit 11 picks low or high maximum power bias.
// (R18) Bias bits 10:9 output as temperature scale; controller advised 10.
// (R19) Bias bit 7 routes external input straight to IF gain stage.
// (R20) Bias bits 6:4 select slope, 1.3 at 000 down to 0.6.
// (R21) Bias bits 3:0 select driver scale, 0.50 up to 1.88.
// (R22) 24-bit frames, MSB first, rising-edge shift, latch on select rising.
// (R23) Controller loads test register with 100 hex.
// (R24) Transmit off on burst pin low or bit; chip off on pin or bit.
module txcrd_top
  import txcrd_pkg::*;
(
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_SER_CLK,
  input  wire logic        I_SER_DATA,
  input  wire logic        I_SER_CS_N,
  input  wire logic        I_TRANSMIT_BURST_ENABLE,
  input  wire logic        I_CHIP_OFF_PIN_N,
  input  wire logic        I_RF_LOCKED,
  input  wire logic        I_IF_ACQ_DONE,
  output logic             O_LO_LOW_PORT,
  output logic             O_LO_HIGH_PORT,
  output logic             O_RF_PUMP_BOOST,
  output logic [1:0]       O_RF_BOOST_MODE,
  output logic             O_IF_PUMP_BOOST,
  output logic             O_CELL_BAND_DRIVER,
  output logic             O_PCS_LOWER_DRIVER,
  output logic             O_PCS_UPPER_DRIVER,
  output logic             O_FM_MODE,
  output logic             O_IF_HIGH_PAIR,
  output logic             O_IF_LOW_PAIR,
  output logic             O_IF_OSC_HIGH,
  output logic             O_IF_OSC_LOW,
  output logic [2:0]       O_IF_GAIN_TRIM,
  output logic             O_UPPER_SIDEBAND,
  output logic             O_LO_OUT_BUFFER_ON,
  output logic             O_QUAD_MOD,
  output logic             O_CHIP_POWERED,
  output logic             O_TX_PATH_POWERED,
  output logic             O_IF_SYNTH_ON,
  output logic             O_RF_SYNTH_ON,
  output logic             O_PRESCALER_HIGH,
  output logic             O_MAX_POWER_HIGH,
  output logic [1:0]       O_THERMAL_BIAS_SCALE,
  output logic             O_MODULATOR_SKIP,
  output logic [2:0]       O_BIAS_SLOPE_RATE,
  output logic [3:0]       O_DRIVER_BIAS_SCALE,
  output logic [15:0]      O_OPERATION_CONTROL_VALUE
);

  // ==========================================================================
  // Link domain: shift register and latch on select release
  // ==========================================================================
  // The serial clock only runs inside a frame, so the frame is captured as
  // it shifts and a toggle announces each completed frame to the core.
  logic [FRAME_BITS-1:0] shift_reg;
  logic [FRAME_BITS-1:0] frame_reg;
  logic                  frame_tgl_reg;

  always_ff @(posedge I_SER_CLK or posedge I_RST) begin
    if (I_RST) begin
      shift_reg <= '0;
    end else if (!I_SER_CS_N) begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], I_SER_DATA}; // [R22]
    end
  end

  // Select rising closes the frame; the shift register is stable by then.
  always_ff @(posedge I_SER_CS_N or posedge I_RST) begin
    if (I_RST) begin
      frame_reg     <= '0;
      frame_tgl_reg <= 1'b0;
    end else begin
      frame_reg     <= shift_reg; // [R22]
      frame_tgl_reg <= ~frame_tgl_reg;
    end
  end

  // ==========================================================================
  // Crossing into the reference clock domain
  // ==========================================================================
  logic [2:0] tgl_sync_reg;
  logic [1:0] burst_sync_reg;
  logic [1:0] off_sync_reg;
  logic [1:0] lock_sync_reg;
  logic [1:0] acq_sync_reg;
  logic       frame_evt;

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      tgl_sync_reg   <= '0;
      burst_sync_reg <= '0;
      off_sync_reg   <= 2'b11;
      lock_sync_reg  <= '0;
      acq_sync_reg   <= '0;
    end else begin
      tgl_sync_reg   <= {tgl_sync_reg[1:0], frame_tgl_reg};
      burst_sync_reg <= {burst_sync_reg[0], I_TRANSMIT_BURST_ENABLE};
      off_sync_reg   <= {off_sync_reg[0], I_CHIP_OFF_PIN_N};
      lock_sync_reg  <= {lock_sync_reg[0], I_RF_LOCKED};
      acq_sync_reg   <= {acq_sync_reg[0], I_IF_ACQ_DONE};
    end
  end

  // Frame word is held stable for many core cycles after the toggle lands.
  assign frame_evt = tgl_sync_reg[2] ^ tgl_sync_reg[1];

  // ==========================================================================
  // Register bank
  // ==========================================================================
  logic [15:0] operation_control_reg;
  logic [15:0] setup_reg;
  logic [15:0] bias_reg;
  logic [3:0]  frame_addr;
  logic [15:0] frame_data;
  logic        rf_reprog_pulse;

  assign frame_addr = frame_reg[ADDR_BITS-1:0];
  assign frame_data = frame_reg[ADDR_BITS+DATA_BITS-1:ADDR_BITS];

  // Registers keep their contents through every power-down mode.
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      operation_control_reg <= RST_OPERATION_CONTROL;
      setup_reg  <= RST_SETUP;
      bias_reg   <= RST_BIAS;
    end else if (frame_evt) begin
      if (frame_addr == ADDR_OPERATION_CONTROL) begin
        operation_control_reg <= frame_data; // [R22]
      end
      if (frame_addr == ADDR_SETUP) begin
        setup_reg <= frame_data;
      end
      if (frame_addr == ADDR_BIAS) begin
        bias_reg <= frame_data; // [R15]
      end
    end
  end

  // RF synthesizer counts sit at addresses 0 and 1; writing them re-arms boost.
  assign rf_reprog_pulse = frame_evt && (frame_addr[3:1] == 3'b000);

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  function automatic txcrd_mode_t decode_mode(input logic [1:0] code);
    unique case (code)
      2'b00: decode_mode = TXCRD_MODE_FM;
      2'b01: decode_mode = TXCRD_MODE_CELL;
      2'b10: decode_mode = TXCRD_MODE_PCS_L;
      2'b11: decode_mode = TXCRD_MODE_PCS_U;
    endcase
  endfunction

  function automatic txcrd_boost_t decode_boost(input logic a, input logic b);
    decode_boost = '0;
    unique case ({a, b})
      2'b00: decode_boost.boost_off    = 1'b1;
      2'b01: decode_boost.boost_reprog = 1'b1;
      2'b10: decode_boost.boost_always = 1'b1;
      2'b11: decode_boost.boost_unlock = 1'b1;
    endcase
  endfunction

  // ==========================================================================
  // Power management
  // ==========================================================================
  logic chip_on;
  logic tx_on;

  assign chip_on = off_sync_reg[1] && operation_control_reg[OP_OFF_N] && operation_control_reg[OP_SLEEP_N]; // [R11] [R13] [R24]
  assign tx_on   = chip_on && burst_sync_reg[1] && operation_control_reg[OP_TXSLP_N]; // [R12] [R24]

  // ==========================================================================
  // Charge-pump boost
  // ==========================================================================
  txcrd_boost_t boost;
  logic         reprog_boost_reg;
  logic         if_boost_reg;

  assign boost = decode_boost(operation_control_reg[OP_BOOST_A], setup_reg[SU_BOOST_B]); // [R2]

  // Boost after reprogramming lasts until the RF loop reports lock.
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      reprog_boost_reg <= 1'b0;
    end else if (rf_reprog_pulse) begin
      reprog_boost_reg <= 1'b1; // [R2]
    end else if (lock_sync_reg[1]) begin
      reprog_boost_reg <= 1'b0;
    end
  end

  // IF boost is on during acquisition, and stays on when held.
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      if_boost_reg <= 1'b0;
    end else begin
      if_boost_reg <= chip_on && setup_reg[SU_IF_SYN_N] &&
                      (!acq_sync_reg[1] || operation_control_reg[OP_IF_HOLD]); // [R3]
    end
  end

  // ==========================================================================
  // Output registers
  // ==========================================================================
  txcrd_mode_t  mode;
  txcrd_drv_t   drv;
  txcrd_route_t route;
  logic         rf_boost;

  assign mode = decode_mode(operation_control_reg[OP_MODE_HI:OP_MODE_LO]); // [R4]
  assign drv  = '{cell_band_driver: tx_on && (mode == TXCRD_MODE_CELL || mode == TXCRD_MODE_FM),
                  pcs_lower_driver: tx_on && (mode == TXCRD_MODE_PCS_L),
                  pcs_upper_driver: tx_on && (mode == TXCRD_MODE_PCS_U)}; // [R4]
  // FM uses the low IF pair; the controller is expected to keep bit 10 clear.
  assign route = '{lo_low_port:  chip_on && !operation_control_reg[OP_LO_PORT_SELECT], // [R1]
                   lo_high_port: chip_on && operation_control_reg[OP_LO_PORT_SELECT],
                   if_low_sel:   !operation_control_reg[OP_IF_PORT], // [R5]
                   if_high_sel:  operation_control_reg[OP_IF_PORT],
                   osc_high:     chip_on && operation_control_reg[OP_OSC_BAND], // [R6]
                   osc_low:      chip_on && !operation_control_reg[OP_OSC_BAND]};
  assign rf_boost = chip_on && setup_reg[SU_RF_SYN_N] &&
                    (boost.boost_always || (boost.boost_reprog && reprog_boost_reg) ||
                     (boost.boost_unlock && !lock_sync_reg[1])); // [R2]

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_LO_LOW_PORT      <= 1'b0;
      O_LO_HIGH_PORT     <= 1'b0;
      O_IF_HIGH_PAIR     <= 1'b0;
      O_IF_LOW_PAIR      <= 1'b0;
      O_IF_OSC_HIGH      <= 1'b0;
      O_IF_OSC_LOW       <= 1'b0;
      O_CELL_BAND_DRIVER <= 1'b0;
      O_PCS_LOWER_DRIVER <= 1'b0;
      O_PCS_UPPER_DRIVER <= 1'b0;
      O_FM_MODE          <= 1'b0;
    end else begin
      O_LO_LOW_PORT      <= route.lo_low_port; // [R1]
      O_LO_HIGH_PORT     <= route.lo_high_port; // [R1]
      O_IF_HIGH_PAIR     <= tx_on && route.if_high_sel; // [R5]
      O_IF_LOW_PAIR      <= tx_on && route.if_low_sel; // [R5]
      O_IF_OSC_HIGH      <= route.osc_high; // [R6]
      O_IF_OSC_LOW       <= route.osc_low; // [R6]
      O_CELL_BAND_DRIVER <= drv.cell_band_driver; // [R4]
      O_PCS_LOWER_DRIVER <= drv.pcs_lower_driver; // [R4]
      O_PCS_UPPER_DRIVER <= drv.pcs_upper_driver; // [R4]
      O_FM_MODE          <= (mode == TXCRD_MODE_FM); // [R4]
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RF_PUMP_BOOST    <= 1'b0;
      O_RF_BOOST_MODE    <= 2'h0;
      O_IF_PUMP_BOOST    <= 1'b0;
      O_IF_GAIN_TRIM     <= RST_OPERATION_CONTROL[OP_GAIN_HI:OP_GAIN_LO];
      O_UPPER_SIDEBAND   <= 1'b0;
      O_LO_OUT_BUFFER_ON <= 1'b0;
      O_QUAD_MOD         <= 1'b0;
      O_CHIP_POWERED     <= 1'b0;
      O_TX_PATH_POWERED  <= 1'b0;
      O_IF_SYNTH_ON      <= 1'b0;
      O_RF_SYNTH_ON      <= 1'b0;
      O_OPERATION_CONTROL_VALUE     <= RST_OPERATION_CONTROL;
    end else begin
      O_RF_PUMP_BOOST    <= rf_boost; // [R2]
      O_RF_BOOST_MODE    <= {operation_control_reg[OP_BOOST_A], setup_reg[SU_BOOST_B]}; // [R2]
      // Gated again here so the boost output drops in the same cycle as chip power.
      O_IF_PUMP_BOOST    <= chip_on && if_boost_reg; // [R3]
      O_IF_GAIN_TRIM     <= operation_control_reg[OP_GAIN_HI:OP_GAIN_LO]; // [R7]
      O_UPPER_SIDEBAND   <= operation_control_reg[OP_SIDE]; // [R8]
      O_LO_OUT_BUFFER_ON <= chip_on && operation_control_reg[OP_BUF_ON]; // [R9]
      O_QUAD_MOD         <= tx_on && operation_control_reg[OP_MOD_KIND]; // [R10]
      O_CHIP_POWERED     <= chip_on; // [R11] [R13] [R24]
      O_TX_PATH_POWERED  <= tx_on; // [R12] [R24]
      O_IF_SYNTH_ON      <= chip_on && setup_reg[SU_IF_SYN_N]; // [R14]
      O_RF_SYNTH_ON      <= chip_on && setup_reg[SU_RF_SYN_N]; // [R14]
      O_OPERATION_CONTROL_VALUE     <= operation_control_reg;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PRESCALER_HIGH     <= 1'b0;
      O_MAX_POWER_HIGH     <= 1'b0;
      O_THERMAL_BIAS_SCALE <= RST_BIAS[BI_THERM_HI:BI_THERM_LO];
      O_MODULATOR_SKIP     <= 1'b0;
      O_BIAS_SLOPE_RATE    <= RST_BIAS[BI_SLOPE_HI:BI_SLOPE_LO];
      O_DRIVER_BIAS_SCALE  <= RST_BIAS[BI_DRV_HI:BI_DRV_LO];
    end else begin
      O_PRESCALER_HIGH     <= bias_reg[BI_PRESCALE]; // [R16]
      O_MAX_POWER_HIGH     <= bias_reg[BI_MAXPWR]; // [R17]
      O_THERMAL_BIAS_SCALE <= bias_reg[BI_THERM_HI:BI_THERM_LO]; // [R18]
      O_MODULATOR_SKIP     <= bias_reg[BI_SKIP]; // [R19]
      O_BIAS_SLOPE_RATE    <= bias_reg[BI_SLOPE_HI:BI_SLOPE_LO]; // [R20]
      O_DRIVER_BIAS_SCALE  <= bias_reg[BI_DRV_HI:BI_DRV_LO]; // [R21]
    end
  end

endmodule : txcrd_top // txcrd_top

`default_nettype wire

// ### bench/txcrd_ctrl_model.sv
// Behavioural baseband controller that shifts frames onto the three-wire bus.
`timescale 1ns/100ps
`default_nettype none
module txcrd_ctrl_model (
  output logic o_ser_clk,
  output logic o_ser_data,
  output logic o_ser_cs_n
);
  // ====================================================
  // Frame shifter
  // ====================================================
  initial begin
    o_ser_clk  = 1'b0;
    o_ser_data = 1'b0;
    o_ser_cs_n = 1'b1;
  end

  // The link clock runs only inside a frame and stands low between frames.
  // The odd start delay keeps its edges off the core clock grid.
  task automatic send(input logic [23:0] frame);
    #3.7;
    o_ser_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_ser_data = frame[i];
      #80;
      o_ser_clk = 1'b1;
      #80;
      o_ser_clk = 1'b0;
    end
    #80;
    o_ser_cs_n = 1'b1;
    // A released data line must not keep showing the last bit.
    o_ser_data = ~o_ser_data;
  endtask
endmodule // txcrd_ctrl_model
`default_nettype wire

// ### bench/txcrd_top_assertions.sv
// Concurrent checks on the outputs of the transmitter control bank.
`timescale 1ns/100ps
`default_nettype none
module txcrd_top_assertions (
  input wire logic        I_REF_CLK,
  input wire logic        I_RST,
  input wire logic        I_SER_CS_N,
  input wire logic        I_TRANSMIT_BURST_ENABLE,
  input wire logic        I_CHIP_OFF_PIN_N,
  input wire logic        O_LO_LOW_PORT,
  input wire logic        O_LO_HIGH_PORT,
  input wire logic        O_RF_PUMP_BOOST,
  input wire logic [1:0]  O_RF_BOOST_MODE,
  input wire logic        O_IF_PUMP_BOOST,
  input wire logic        O_CELL_BAND_DRIVER,
  input wire logic        O_PCS_LOWER_DRIVER,
  input wire logic        O_PCS_UPPER_DRIVER,
  input wire logic        O_IF_HIGH_PAIR,
  input wire logic        O_IF_LOW_PAIR,
  input wire logic        O_IF_OSC_HIGH,
  input wire logic        O_IF_OSC_LOW,
  input wire logic        O_QUAD_MOD,
  input wire logic        O_CHIP_POWERED,
  input wire logic        O_TX_PATH_POWERED,
  input wire logic        O_IF_SYNTH_ON,
  input wire logic        O_RF_SYNTH_ON,
  input wire logic [3:0]  O_DRIVER_BIAS_SCALE,
  input wire logic [15:0] O_OPERATION_CONTROL_VALUE
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);

  // ====================================================
  // Sequences
  // ====================================================
  // Four samples cover the two synchronizer stages and the output register.
  sequence s_pin_low;
    !I_CHIP_OFF_PIN_N [*4];
  endsequence
  sequence s_burst_low;
    !I_TRANSMIT_BURST_ENABLE [*4];
  endsequence
  sequence s_link_idle;
    I_SER_CS_N [*8];
  endsequence

  // ====================================================
  // Assertions
  // ====================================================
  a_drv_onehot: assert property ($onehot0({O_CELL_BAND_DRIVER, O_PCS_LOWER_DRIVER, O_PCS_UPPER_DRIVER}))
    else $error("more than one transmit driver active");
  a_drv_needs_tx: assert property ((O_CELL_BAND_DRIVER | O_PCS_LOWER_DRIVER | O_PCS_UPPER_DRIVER | O_QUAD_MOD)
    |-> O_TX_PATH_POWERED) else $error("driver or modulator on with transmit path off");
  a_tx_in_chip: assert property (O_TX_PATH_POWERED |-> O_CHIP_POWERED)
    else $error("transmit path powered while chip off");
  a_lo_route: assert property ((O_LO_LOW_PORT ^ O_LO_HIGH_PORT) == O_CHIP_POWERED)
    else $error("LO port routing not exclusive");
  a_osc_band: assert property ((O_IF_OSC_HIGH ^ O_IF_OSC_LOW) == O_CHIP_POWERED)
    else $error("IF oscillator band not exclusive");
  a_if_pair: assert property ((O_IF_HIGH_PAIR ^ O_IF_LOW_PAIR) == O_TX_PATH_POWERED)
    else $error("IF pair selection not exclusive");
  a_synth_off: assert property (!O_CHIP_POWERED |-> !(O_IF_SYNTH_ON | O_RF_SYNTH_ON | O_IF_PUMP_BOOST))
    else $error("synthesizer active while chip off");
  a_boost_none: assert property (O_RF_BOOST_MODE == 2'b00 |-> !O_RF_PUMP_BOOST)
    else $error("RF boost active with boost disabled");
  a_pin_off: assert property (s_pin_low |-> !O_CHIP_POWERED)
    else $error("chip powered with shutdown pin low");
  a_burst_off: assert property (s_burst_low |-> !O_TX_PATH_POWERED)
    else $error("transmit path on with burst pin low");
  a_hold_idle: assert property (s_link_idle |=> $stable(O_OPERATION_CONTROL_VALUE) && $stable(O_DRIVER_BIAS_SCALE))
    else $error("register contents changed without a frame");
endmodule // txcrd_top_assertions

bind txcrd_top txcrd_top_assertions txcrd_top_assertions_i (.*);
`default_nettype wire

// ### bench/test_txcrd_top.sv
// Self-checking bench for the transmitter control bank.
`timescale 1ns/100ps
`default_nettype none
module test_txcrd_top;
  import txcrd_pkg::*;
  logic        clk;
  logic        rst;
  logic        burst;
  logic        pin_n;
  logic        locked;
  logic        acq;
  logic        boost;
  wire  [50:0] seen;
  logic [15:0] op_v;
  logic [15:0] su_v;
  logic [15:0] bi_v;
  logic [15:0] d;
  logic [31:0] seed;
  logic [15:0] bias_tab [3] = '{16'h2eff, 16'h0000, 16'h0438};
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;
  wire         sck;
  wire         sdat;
  wire         scs_n;

  txcrd_ctrl_model ctrl_i (.o_ser_clk(sck), .o_ser_data(sdat), .o_ser_cs_n(scs_n));

  txcrd_top txcrd_top_i (
    .I_REF_CLK(clk), .I_RST(rst), .I_SER_CLK(sck), .I_SER_DATA(sdat), .I_SER_CS_N(scs_n),
    .I_TRANSMIT_BURST_ENABLE(burst), .I_CHIP_OFF_PIN_N(pin_n), .I_RF_LOCKED(locked), .I_IF_ACQ_DONE(acq),
    .O_LO_LOW_PORT(seen[50]), .O_LO_HIGH_PORT(seen[49]), .O_RF_PUMP_BOOST(boost),
    .O_RF_BOOST_MODE(seen[48:47]), .O_IF_PUMP_BOOST(seen[46]), .O_CELL_BAND_DRIVER(seen[45]),
    .O_PCS_LOWER_DRIVER(seen[44]), .O_PCS_UPPER_DRIVER(seen[43]), .O_FM_MODE(seen[42]),
    .O_IF_HIGH_PAIR(seen[41]), .O_IF_LOW_PAIR(seen[40]), .O_IF_OSC_HIGH(seen[39]), .O_IF_OSC_LOW(seen[38]),
    .O_IF_GAIN_TRIM(seen[37:35]), .O_UPPER_SIDEBAND(seen[34]), .O_LO_OUT_BUFFER_ON(seen[33]),
    .O_QUAD_MOD(seen[32]), .O_CHIP_POWERED(seen[31]), .O_TX_PATH_POWERED(seen[30]),
    .O_IF_SYNTH_ON(seen[29]), .O_RF_SYNTH_ON(seen[28]), .O_PRESCALER_HIGH(seen[27]),
    .O_MAX_POWER_HIGH(seen[26]), .O_THERMAL_BIAS_SCALE(seen[25:24]), .O_MODULATOR_SKIP(seen[23]),
    .O_BIAS_SLOPE_RATE(seen[22:20]), .O_DRIVER_BIAS_SCALE(seen[19:16]), .O_OPERATION_CONTROL_VALUE(seen[15:0])
  );

  // ====================================================
  // Expectations and helpers
  // ====================================================
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [50:0] expect_out(input logic [15:0] op, su, bi, input logic b, p, a);
    logic c;
    logic t;
    logic [1:0] m;
    c = p & op[0] & op[2];
    t = c & b & op[1];
    m = op[12:11];
    return {c & !op[15], c & op[15], op[14], su[13], c & su[15] & (!a | op[13]),
            t & !m[1], t & (m == 2'b10), t & (m == 2'b11), m == 2'b00, t & op[10], t & !op[10],
            c & op[9], c & !op[9], op[8:6], op[5], op[4] & c, op[3] & t, c, t, su[15] & c, su[14] & c,
            bi[13], bi[11], bi[10:9], bi[7], bi[6:4], bi[3:0], op};
  endfunction

  task automatic end_sim();
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string name, input logic [50:0] got, input logic [50:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_all();
    check("outputs", seen, expect_out(op_v, su_v, bi_v, burst, pin_n, acq));
  endtask

  // Frames carry a random don't-care nibble on top of data and address.
  task automatic wr(input logic [3:0] ad, input logic [15:0] dv);
    seed = lfsr(seed);
    ctrl_i.send({seed[3:0], dv, ad});
    if (ad == ADDR_OPERATION_CONTROL) op_v = dv;
    if (ad == ADDR_SETUP) su_v = dv;
    if (ad == ADDR_BIAS) bi_v = dv;
    repeat (10) @(posedge clk);
  endtask

  task automatic set_pins(input logic b, p, l, a);
    @(posedge clk);
    #1;
    burst = b;
    pin_n = p;
    locked = l;
    acq = a;
  endtask

  // ====================================================
  // Clock, watchdog and main sequence
  // ====================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    seed = 32'h47cc;
    rst = 1'b1;
    {burst, pin_n, locked, acq} = 4'hf;
    op_v = RST_OPERATION_CONTROL;
    su_v = RST_SETUP;
    bi_v = RST_BIAS;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    cmp_all();
    wr(4'h7, 16'h0100);
    cmp_all();
    for (int i = 0; i < 32; i++) begin
      wr(ADDR_OPERATION_CONTROL, 16'h0108 | {3'h0, i[1:0], 8'h0, i[4:2]});
      cmp_all();
    end
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_BIAS, bias_tab[i]);
      cmp_all();
    end
    for (int n = 0; n < 14; n++) begin
      seed = lfsr(seed);
      d = seed[15:0];
      if (d[12:11] == 2'b00) d[10] = 1'b0;
      wr(ADDR_OPERATION_CONTROL, d);
      seed = lfsr(seed);
      wr(ADDR_SETUP, seed[15:0]);
      seed = lfsr(seed);
      wr(ADDR_BIAS, seed[15:0] & 16'h2eff);
      wr(seed[19:16] | 4'h8, seed[31:16]);
      set_pins(seed[20], seed[21] | seed[22], seed[23], seed[24]);
      repeat (6) @(posedge clk);
      cmp_all();
    end
    set_pins(1'b1, 1'b1, 1'b1, 1'b1);
    wr(ADDR_BIAS, RST_BIAS);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_OPERATION_CONTROL, RST_OPERATION_CONTROL | {1'b0, k[1], 14'h0});
      wr(ADDR_SETUP, RST_SETUP | {2'b0, k[0], 13'h0});
      for (int l = 0; l < 2; l++) begin
        set_pins(1'b1, 1'b1, l[0], 1'b1);
        if (k == 1 && l == 0) wr(4'h0, 16'h1234);
        repeat (6) @(posedge clk);
        check("rf boost", {50'h0, boost}, {50'h0, (k[1] & !k[0]) | (k[0] & !l[0])});
      end
    end
    end_sim();
  end
endmodule // test_txcrd_top
`default_nettype wire
